// >>> spc_far_end.sv
/*
 Far-side serial device model: select pin level and data line answers.
 Assumes it resolves both data wires from the enables of both parties.
*/
`timescale 1ns/100ps
module spc_far_end (
   input wire logic core_clk,
   input wire logic sel_level,
   input wire logic far_en,
   input wire logic far_bit,
   input wire logic m_out,
   input wire logic m_oe_n,
   input wire logic s_out,
   input wire logic s_oe_n,
   output logic select_in,
   output logic m_pin,
   output logic s_pin
);
   logic churn = 1'b0;
   // Released lines show far_bit when far_en is set, else a pattern that changes every cycle
   always @(posedge core_clk) churn <= ~churn;
   assign select_in = sel_level;
   assign m_pin = !m_oe_n ? m_out : (far_en ? far_bit : churn);
   assign s_pin = !s_oe_n ? s_out : (far_en ? far_bit : churn);
endmodule

// >>> spc_pkg.sv
/*
 Constants shared by the serial pin and baud configuration block.
 Assumes a single core clock domain.
*/
package spc_pkg;
   localparam logic [7:0] SPC_OFS_CTRL2 = 8'h01;
   localparam logic [7:0] SPC_OFS_BAUD = 8'h02;
   localparam logic [7:0] SPC_OFS_STATUS = 8'h03;
   localparam logic [7:0] SPC_OFS_MODE = 8'h04;
   localparam int SPC_POS_FAULT_EN = 4;
   localparam int SPC_POS_SHARED_OE = 3;
   localparam int SPC_POS_HALT_WAIT = 1;
   localparam int SPC_POS_SINGLE_WIRE = 0;
   localparam int SPC_POS_MASTER = 0;
   localparam logic [7:0] SPC_CTRL2_RESET = 8'h00;
   localparam logic [7:0] SPC_BAUD_RESET = 8'h00;
   localparam logic [7:0] SPC_MODE_RESET = 8'h00;
   localparam logic [7:0] SPC_CTRL2_MASK = 8'h1B;
   localparam logic [7:0] SPC_BAUD_MASK = 8'h77;
endpackage

// >>> spc_top.sv
/*
 Serial pin routing and two-stage baud generator with register port.
 Assumes a register master on core_clk and raw pins from outside.
*/
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/100ps
// Behaviour
// - Slave mode ignores fault enable; select pin is always select input
// - Master with fault enable 0 releases select pin to general I/O
// - Master with fault enable 1 uses select pin as fault input or output
// - Single-wire bit 0 uses two data pins; 1 uses one shared pin
// - Single wire: master uses master-out pin, slave uses master-in pin
// - Shared output enable ignored when single-wire bit is 0
// - Single wire: output enable 0 makes pin input, 1 drives it
// - Halt-in-wait set stops clocks in wait; clear keeps them running
// - Prescaler divides bus clock by one of eight, field bits 6:4
// - Second stage divides prescaler output; field bits 2:0; bit clock
// - Baud register readable and writable at any time
module spc_top
   import spc_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic cpu_wait,
   input wire logic select_in,
   output logic select_out,
   output logic select_oe_n,
   output logic select_owned,
   output logic fault_detect,
   input wire logic xfer_busy,
   input wire logic master_shared_data_pin_in,
   output logic master_shared_data_pin_out,
   output logic master_shared_data_pin_oe_n,
   input wire logic slave_shared_data_pin_in,
   output logic slave_shared_data_pin_out,
   output logic slave_shared_data_pin_oe_n,
   input wire logic tx_bit,
   output logic rx_bit,
   input wire logic [7:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [7:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic bit_clk_tick,
   output logic clk_run
);
   typedef enum logic [1:0] {
      SPC_RUN_T = 2'b01,
      SPC_HALT_T = 2'b10
   } spc_state_t;

   logic [7:0] serial_control_two;
   logic [7:0] serial_baud_select;
   logic [7:0] mode_reg;
   logic [2:0] sel_sync;
   logic [2:0] mo_sync;
   logic [2:0] si_sync;
   logic sel_level;
   logic mo_level;
   logic si_level;
   logic fault_seen;
   logic [2:0] pre_cnt;
   logic [7:0] div_cnt;
   logic pre_tick;
   logic tick_q;
   spc_state_t state;
   spc_state_t next_state;
   logic [7:0] buf_data [0:1];
   logic [1:0] buf_cnt;
   logic buf_wp;
   logic buf_rp;

   function automatic logic [8:0] spc_rate_div(input logic [2:0] f);
      logic [3:0] sh;
      sh = {1'b0, f} + 4'h1;
      spc_rate_div = 9'h001 << sh;
   endfunction

   function automatic logic agree(input logic [2:0] s, input logic cur);
      agree = (s[1] == s[2]) ? s[2] : cur;
   endfunction

   wire master_select = mode_reg[SPC_POS_MASTER];
   wire fault_detect_enable = serial_control_two[SPC_POS_FAULT_EN];
   wire shared_pin_output_enable = serial_control_two[SPC_POS_SHARED_OE];
   wire halt_in_wait = serial_control_two[SPC_POS_HALT_WAIT];
   wire single_wire_select = serial_control_two[SPC_POS_SINGLE_WIRE];
   wire [2:0] baud_prescale_field = serial_baud_select[6:4];
   wire [2:0] baud_divide_field = serial_baud_select[2:0];
   wire wr_ctrl2 = reg_wr && (reg_addr == SPC_OFS_CTRL2);
   wire wr_baud = reg_wr && (reg_addr == SPC_OFS_BAUD);
   wire wr_mode = reg_wr && (reg_addr == SPC_OFS_MODE);
   wire sel_drive = master_select && fault_detect_enable && xfer_busy;
   wire drive_shared = single_wire_select && shared_pin_output_enable;
   wire pre_last = pre_cnt == baud_prescale_field;
   wire div_last = {1'b0, div_cnt} ==
      (spc_rate_div(baud_divide_field) - 9'h001);
   wire [7:0] rd_mux = (reg_addr == SPC_OFS_CTRL2) ? serial_control_two :
      (reg_addr == SPC_OFS_BAUD) ? serial_baud_select :
      (reg_addr == SPC_OFS_MODE) ? mode_reg :
      (reg_addr == SPC_OFS_STATUS) ?
         {5'h00, clk_run, fault_seen, sel_level} : 8'h00;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         serial_control_two <= SPC_CTRL2_RESET;
         serial_baud_select <= SPC_BAUD_RESET;
         mode_reg <= SPC_MODE_RESET;
         reg_rdata <= 8'h00;
      end else begin
         if (wr_ctrl2) serial_control_two <= reg_wdata & SPC_CTRL2_MASK;
         if (wr_baud) serial_baud_select <= reg_wdata & SPC_BAUD_MASK;
         if (wr_mode) mode_reg <= reg_wdata & 8'h01;
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sel_sync <= 3'h7;
         mo_sync <= 3'h0;
         si_sync <= 3'h0;
         sel_level <= 1'b1;
         mo_level <= 1'b0;
         si_level <= 1'b0;
      end else begin
         sel_sync <= {sel_sync[1:0], select_in};
         mo_sync <= {mo_sync[1:0], master_shared_data_pin_in};
         si_sync <= {si_sync[1:0], slave_shared_data_pin_in};
         sel_level <= agree(sel_sync, sel_level);
         mo_level <= agree(mo_sync, mo_level);
         si_level <= agree(si_sync, si_level);
      end
   end

   // Select pin ownership
   assign select_owned = !master_select || fault_detect_enable;
   assign select_out = 1'b0;
   assign select_oe_n = !sel_drive;
   wire fault_now = master_select && fault_detect_enable && !xfer_busy &&
      !sel_level;
   assign fault_detect = fault_seen;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) fault_seen <= 1'b0;
      else if (fault_now) fault_seen <= 1'b1;
      else if (wr_mode) fault_seen <= 1'b0;
   end

   // Data pin routing
   assign master_shared_data_pin_out = tx_bit;
   assign slave_shared_data_pin_out = tx_bit;
   assign master_shared_data_pin_oe_n = single_wire_select ?
      !(master_select && drive_shared) : !master_select;
   assign slave_shared_data_pin_oe_n = single_wire_select ?
      !(!master_select && drive_shared) : master_select;
   assign rx_bit = single_wire_select ?
      (master_select ? mo_level : si_level) :
      (master_select ? si_level : mo_level);

   // Wait-mode clock gating
   always_comb begin
      next_state = state;
      case (state)
         SPC_RUN_T: if (cpu_wait && halt_in_wait) next_state = SPC_HALT_T;
         SPC_HALT_T: if (!(cpu_wait && halt_in_wait)) next_state = SPC_RUN_T;
         default: next_state = SPC_RUN_T;
      endcase
   end
   assign clk_run = state == SPC_RUN_T;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) state <= SPC_RUN_T;
      else state <= next_state;
   end

   // Baud prescaler and divider
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_cnt <= 3'h0;
         pre_tick <= 1'b0;
      end else if (!clk_run || wr_baud) begin
         pre_cnt <= 3'h0;
         pre_tick <= 1'b0;
      end else begin
         pre_tick <= pre_last;
         pre_cnt <= pre_last ? 3'h0 : pre_cnt + 3'h1;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt <= 8'h00;
         tick_q <= 1'b0;
      end else if (!clk_run || wr_baud) begin
         div_cnt <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         tick_q <= pre_tick && div_last && master_select;
         if (pre_tick) div_cnt <= div_last ? 8'h00 : div_cnt + 8'h01;
      end
   end
   assign bit_clk_tick = tick_q;

   // Two-entry data buffer
   assign in_ready = buf_cnt != 2'h2;
   assign out_valid = buf_cnt != 2'h0;
   assign out_data = buf_data[buf_rp];

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         buf_cnt <= 2'h0;
         buf_wp <= 1'b0;
         buf_rp <= 1'b0;
         buf_data[0] <= 8'h00;
         buf_data[1] <= 8'h00;
      end else begin
         if (push) begin
            buf_data[buf_wp] <= in_data;
            buf_wp <= !buf_wp;
         end
         if (pop) buf_rp <= !buf_rp;
         buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
      end
   end

   // Checks
   chk_slave_select_free: assert property (@(posedge core_clk)
      disable iff (!arst_n) !master_select |-> select_oe_n && select_owned)
      else $error("select pin driven in slave mode");
   chk_fault_slave: assert property (@(posedge core_clk)
      disable iff (!arst_n) !master_select && !fault_detect |=> !fault_detect)
      else $error("mode fault raised in slave mode");
   chk_release_gpio: assert property (@(posedge core_clk)
      disable iff (!arst_n) master_select && !fault_detect_enable |->
      !select_owned && select_oe_n)
      else $error("select pin held without fault enable");
   chk_fault_latch: assert property (@(posedge core_clk)
      disable iff (!arst_n) fault_now |=> fault_detect)
      else $error("mode fault not latched");
   chk_fault_clear: assert property (@(posedge core_clk)
      disable iff (!arst_n) wr_mode && !fault_now |=> !fault_detect)
      else $error("mode fault not cleared");
   chk_select_drive: assert property (@(posedge core_clk)
      disable iff (!arst_n) master_select && fault_detect_enable && xfer_busy
      |-> !select_oe_n)
      else $error("select output not driven in transfer");
   chk_two_pin_mode: assert property (@(posedge core_clk)
      disable iff (!arst_n) !single_wire_select |->
      master_shared_data_pin_oe_n != slave_shared_data_pin_oe_n)
      else $error("two-pin mode drives wrong pins");
   chk_slave_shared_pin: assert property (@(posedge core_clk)
      disable iff (!arst_n) single_wire_select && !master_select |->
      master_shared_data_pin_oe_n)
      else $error("slave drives master-out pin");
   chk_master_shared_pin: assert property (@(posedge core_clk)
      disable iff (!arst_n) single_wire_select && shared_pin_output_enable &&
      master_select |-> !master_shared_data_pin_oe_n &&
      slave_shared_data_pin_oe_n)
      else $error("master shared pin not driven");
   chk_slave_shared_drive: assert property (@(posedge core_clk)
      disable iff (!arst_n) single_wire_select && shared_pin_output_enable &&
      !master_select |-> !slave_shared_data_pin_oe_n)
      else $error("slave shared pin not driven");
   chk_shared_dir: assert property (@(posedge core_clk)
      disable iff (!arst_n) single_wire_select && !shared_pin_output_enable
      |-> master_shared_data_pin_oe_n && slave_shared_data_pin_oe_n)
      else $error("shared pin driven while input");
   chk_wait_halt: assert property (@(posedge core_clk)
      disable iff (!arst_n) cpu_wait && halt_in_wait |=> !clk_run ##1
      !bit_clk_tick)
      else $error("clocks run in wait");
   chk_keep_running: assert property (@(posedge core_clk)
      disable iff (!arst_n) clk_run && !(cpu_wait && halt_in_wait) |=>
      clk_run)
      else $error("clocks stopped without halt request");
   chk_halt_prescale: assert property (@(posedge core_clk)
      disable iff (!arst_n) !clk_run |=> !pre_tick && !bit_clk_tick)
      else $error("baud counters run while halted");
   chk_pre_period: assert property (@(posedge core_clk)
      disable iff (!arst_n) pre_tick && clk_run && !wr_baud &&
      baud_prescale_field == 3'h1 ##1 !wr_baud && clk_run |=>
      pre_tick)
      else $error("prescale period wrong");
   chk_tick_master: assert property (@(posedge core_clk)
      disable iff (!arst_n) bit_clk_tick |-> $past(master_select))
      else $error("bit clock outside master mode");
   chk_tick_gap: assert property (@(posedge core_clk)
      disable iff (!arst_n) bit_clk_tick |=> !bit_clk_tick)
      else $error("bit clock pulse too long");
   chk_baud_write: assert property (@(posedge core_clk)
      disable iff (!arst_n) wr_baud |=>
      serial_baud_select == ($past(reg_wdata) & SPC_BAUD_MASK))
      else $error("baud write lost");
   chk_rdata_idle: assert property (@(posedge core_clk)
      disable iff (!arst_n) !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
   chk_buf_hold: assert property (@(posedge core_clk)
      disable iff (!arst_n) out_valid && !out_ready |=>
      out_valid && $stable(out_data))
      else $error("buffered word lost while stalled");
   cov_bit_tick: cover property (@(posedge core_clk) bit_clk_tick);
   cov_fault: cover property (@(posedge core_clk) fault_now);
   cov_buf_full: cover property (@(posedge core_clk) !in_ready);
   cov_halt: cover property (@(posedge core_clk) !clk_run);
   cov_shared_drive: cover property (@(posedge core_clk)
      single_wire_select && shared_pin_output_enable);
endmodule

// >>> test_spc_pin_and_baud_config.sv
/*
 Register, pin routing, baud, wait halt and buffer tests for spc_top.
 Assumes the far-side model resolves the shared data wires.
*/
`timescale 1ns/100ps
module test_spc_pin_and_baud_config;
   import spc_pkg::*;
   logic core_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, cpu_wait = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, in_data = 0, reg_rdata, out_data;
   logic sel_level = 1, far_en = 0, far_bit = 0, xfer_busy = 0, tx_bit = 1;
   logic in_valid = 0, out_ready = 0, select_in, select_out, select_oe_n;
   logic select_owned, fault_detect, m_in, m_out, m_oe_n, s_in, s_out, s_oe_n;
   logic rx_bit, in_ready, out_valid, bit_clk_tick, clk_run, em, es;
   logic [7:0] d;
   int bad_count = 0, n_compared = 0, n, i;
   int bauds [6] = '{8'h00, 8'h70, 8'h07, 8'h23, 8'h77, 8'h12};
   int pers [6] = '{2, 16, 256, 48, 2048, 16};
   initial forever #50 core_clk = ~core_clk;
   spc_top uut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cpu_wait(cpu_wait), .select_in(select_in),
      .select_out(select_out), .select_oe_n(select_oe_n),
      .select_owned(select_owned), .fault_detect(fault_detect),
      .xfer_busy(xfer_busy), .master_shared_data_pin_in(m_in),
      .master_shared_data_pin_out(m_out), .master_shared_data_pin_oe_n(m_oe_n),
      .slave_shared_data_pin_in(s_in), .slave_shared_data_pin_out(s_out),
      .slave_shared_data_pin_oe_n(s_oe_n), .tx_bit(tx_bit), .rx_bit(rx_bit),
      .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
      .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
      .bit_clk_tick(bit_clk_tick), .clk_run(clk_run));
   spc_far_end far (.core_clk(core_clk), .sel_level(sel_level),
      .far_en(far_en), .far_bit(far_bit), .m_out(m_out), .m_oe_n(m_oe_n),
      .s_out(s_out), .s_oe_n(s_oe_n), .select_in(select_in), .m_pin(m_in),
      .s_pin(s_in));
   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_reg({7'h00, got}, {7'h00, exp});
   endtask
   task automatic cmp_num(input int got, input int exp);
      n_compared++;
      if (got != exp) begin
         bad_count++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
      @(posedge core_clk) reg_wr <= 0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk) {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge core_clk) reg_rd <= 0;
      @(posedge core_clk) v = reg_rdata;
   endtask
   task automatic settle(input int c);
      repeat (c) @(posedge core_clk);
      #1;
   endtask
   task automatic period(output int p);
      i = 0;
      do @(posedge core_clk); while (bit_clk_tick !== 1 && ++i < 5000);
      p = 0;
      do begin @(posedge core_clk); p++; end
      while (bit_clk_tick !== 1 && p < 5000);
   endtask
   task automatic ticks(input int span, output int k);
      k = 0;
      repeat (span) @(posedge core_clk) if (bit_clk_tick === 1) k++;
   endtask
   task automatic push(input logic [7:0] v);
      @(posedge core_clk) {in_data, in_valid} <= {v, 1'b1};
      do @(posedge core_clk); while (in_ready !== 1);
      in_valid <= 0;
   endtask
   task automatic pop(output logic [7:0] v);
      @(posedge core_clk) out_ready <= 1;
      do @(posedge core_clk); while (out_valid !== 1);
      v = out_data;
      out_ready <= 0;
   endtask
   initial begin
      repeat (60000) @(posedge core_clk);
      bad_count++;
      end_of_test();
   end
   initial begin
      repeat (5) @(posedge core_clk);
      arst_n <= 1;
      rd(SPC_OFS_CTRL2, d); cmp_reg(d, SPC_CTRL2_RESET);
      rd(SPC_OFS_BAUD, d); cmp_reg(d, SPC_BAUD_RESET);
      rd(SPC_OFS_MODE, d); cmp_reg(d, SPC_MODE_RESET);
      wr(8'hFF, 8'hFF); rd(8'hFF, d); cmp_reg(d, 8'h00);
      xfer_busy <= 1;
      wr(SPC_OFS_CTRL2, 8'hFF); rd(SPC_OFS_CTRL2, d); cmp_reg(d, 8'h1B);
      wr(SPC_OFS_BAUD, 8'hFF); rd(SPC_OFS_BAUD, d); cmp_reg(d, 8'h77);
      sel_level <= 0;
      wr(SPC_OFS_MODE, 8'h00); wr(SPC_OFS_CTRL2, 8'h10); settle(6);
      cmp_bit(select_oe_n, 1);
      cmp_bit(fault_detect, 0);
      wr(SPC_OFS_MODE, 8'h01); wr(SPC_OFS_CTRL2, 8'h00); settle(6);
      cmp_bit(select_owned, 0);
      cmp_bit(select_oe_n, 1);
      wr(SPC_OFS_CTRL2, 8'h10); settle(1);
      cmp_bit(select_owned, 1);
      cmp_bit(select_oe_n, 0);
      cmp_bit(select_out, 0);
      @(posedge core_clk) xfer_busy <= 0; settle(6);
      cmp_bit(fault_detect, 1);
      rd(SPC_OFS_STATUS, d); cmp_reg(d, 8'h06);
      sel_level <= 1; settle(6); wr(SPC_OFS_MODE, 8'h01); settle(6);
      cmp_bit(fault_detect, 0);
      for (int k = 0; k < 8; k++) begin
         wr(SPC_OFS_MODE, {7'h00, k[2]});
         wr(SPC_OFS_CTRL2, {4'h0, k[0], 2'b00, k[1]});
         em = k[1] ? (k[2] ? !k[0] : 1'b1) : !k[2];
         es = k[1] ? (k[2] ? 1'b1 : !k[0]) : k[2];
         {far_en, far_bit} <= {1'b1, k[0]}; settle(6);
         cmp_bit(m_oe_n, em);
         cmp_bit(s_oe_n, es);
         cmp_bit(m_out && s_out, 1);
         if ((k[1] == k[2] ? em : es) == 1)
            cmp_bit(rx_bit, k[0]);
         far_en <= 0;
      end
      wr(SPC_OFS_MODE, 8'h01); wr(SPC_OFS_CTRL2, 8'h00);
      for (int k = 0; k < 6; k++) begin
         wr(SPC_OFS_BAUD, bauds[k][7:0]);
         period(n); cmp_num(n, pers[k]);
      end
      wr(SPC_OFS_BAUD, 8'h00); wr(SPC_OFS_CTRL2, 8'h02);
      cpu_wait <= 1; settle(3);
      cmp_bit(clk_run, 0);
      ticks(40, n); cmp_num(n, 0);
      wr(SPC_OFS_CTRL2, 8'h00); settle(3);
      cmp_bit(clk_run, 1);
      ticks(40, n); cmp_num(n, 20);
      cpu_wait <= 0;
      push(8'hA5); push(8'h5A); settle(2);
      cmp_bit(in_ready, 0);
      pop(d); cmp_reg(d, 8'hA5);
      pop(d); cmp_reg(d, 8'h5A);
      settle(2); cmp_bit(out_valid, 0);
      end_of_test();
   end
endmodule
